// file: core/srxl_map.svh
`ifndef SRXL_MAP_SVH
`define SRXL_MAP_SVH
// ****************************************
// clock and timing
// ****************************************
`define SRXL_CLK_PERIOD_NS   50
`define SRXL_LPF_TAU_NS      67000
`define SRXL_LPF_CYC         (`SRXL_LPF_TAU_NS / `SRXL_CLK_PERIOD_NS)
// ****************************************
// phase lock threshold, 0.66 as a ratio
// ****************************************
`define SRXL_PL_THR_NUM      7'h42
`define SRXL_PL_THR_DEN      7'h64
// ****************************************
// deserializer
// ****************************************
`define SRXL_WORD_BITS       20
`define SRXL_WORD_HALF       10
// ****************************************
// register offsets
// ****************************************
`define SRXL_OFS_CTRL        8'h00
`define SRXL_OFS_STATUS      8'h04
`define SRXL_OFS_INT_STAT    8'h08
`define SRXL_OFS_INT_EN      8'h0C
`define SRXL_OFS_INT_CLR     8'h10
`define SRXL_OFS_FILTER      8'h14
// ****************************************
// field positions and reset values
// ****************************************
`define SRXL_CTRL_SWEEP_EN   0
`define SRXL_CTRL_RST        32'h0000_0001
`define SRXL_INT_LOCK_RISE   0
`define SRXL_INT_LOCK_FALL   1
`define SRXL_INT_NO_DATA     2
`define SRXL_INT_BITS        3
`endif

// file: core/srxl_pkg.sv
`default_nettype none
package srxl_pkg;
  // gray order along acquisition: up, down, track
  typedef enum logic [1:0] {
    SRXL_ACQ_UP   = 2'b00,
    SRXL_ACQ_DOWN = 2'b01,
    SRXL_TRACK    = 2'b11
  } srxl_acq_t;
  typedef logic [1:0] srxl_resp_t;
  localparam srxl_resp_t SRXL_RESP_OKAY   = 2'b00;
  localparam srxl_resp_t SRXL_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: core/srxl_top.sv
// Overview of operation
// - lock output is high only when data is present and phase lock holds
// - integrator pinned at either extreme means no input data
// - while acquiring, a sweep step is added to the integrator
// - the sweep stops as soon as phase lock is asserted
// - the sweep direction reverses whenever the integrator saturates
// - quadrature level is captured on each rising data transition
// - phase lock when average of high quadrature samples exceeds 0.66
// - samples are averaged over a window of about 67 us
// - bypass select low routes data around the retime and mute path
// - in bypass the mute has no effect on the output
// - in bypass the recovery loop and lock report keep running
// - driver enable is active low; output obeys its level
// - serial bits are gathered into consecutive 20-bit words
// - words carry no alignment and no descrambling
// - word clock runs at one twentieth of the bit rate
// - word clock keeps toggling when lock is lost
// - data is taken on the rising edge of the recovered clock
`include "srxl_map.svh"
`default_nettype none
module srxl_top #(
  parameter int INTEG_W = 10,
  parameter int LPF_CYC = `SRXL_LPF_CYC
) (
  // clock and reset (aclk stands for the recovered bit clock)
  input  wire  logic               aclk,
  input  wire  logic               aresetn,
  // serial side pins
  input  wire  logic               serial_data_in,
  input  wire  logic               quad_clk_level,
  input  wire  logic               pd_late,
  input  wire  logic               bypass_sel_n,
  input  wire  logic               serial_out_driver_enable_n,
  // serial and parallel outputs
  output var   logic               retimed_serial_out,
  output var   logic               retimed_serial_out_oe,
  output var   logic [19:0]        word_data,
  output var   logic               word_clk,
  output var   logic               lock,
  output var   logic [INTEG_W-1:0] integrator_level,
  output var   logic [10:0]        lock_filter_node,
  output var   logic               irq,
  // axi4-lite write address and data
  input  wire  logic [7:0]         s_axi_awaddr,
  input  wire  logic               s_axi_awvalid,
  output var   logic               s_axi_awready,
  input  wire  logic [31:0]        s_axi_wdata,
  input  wire  logic [3:0]         s_axi_wstrb,
  input  wire  logic               s_axi_wvalid,
  output var   logic               s_axi_wready,
  // axi4-lite write response
  output var   logic [1:0]         s_axi_bresp,
  output var   logic               s_axi_bvalid,
  input  wire  logic               s_axi_bready,
  // axi4-lite read
  input  wire  logic [7:0]         s_axi_araddr,
  input  wire  logic               s_axi_arvalid,
  output var   logic               s_axi_arready,
  output var   logic [31:0]        s_axi_rdata,
  output var   logic [1:0]         s_axi_rresp,
  output var   logic               s_axi_rvalid,
  input  wire  logic               s_axi_rready
);
  localparam logic [INTEG_W-1:0] INTEG_MAX = '1;
  localparam logic [INTEG_W-1:0] INTEG_MID = INTEG_MAX >> 1;
  localparam logic [10:0] WIN_LAST = 11'(LPF_CYC - 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pin_m_q, pin_s_q;
  logic data_s, quad_s, late_s, bypass_s, den_n_s, data_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle pin levels: not bypassed, driver off, so no false edge
      pin_m_q <= 5'h18;
      pin_s_q <= 5'h18;
      data_prev_q <= 1'b0;
    end else begin
      pin_m_q <= {serial_out_driver_enable_n, bypass_sel_n, pd_late,
                  quad_clk_level, serial_data_in};
      pin_s_q <= pin_m_q;
      data_prev_q <= pin_s_q[0];
    end
  end
  assign data_s   = pin_s_q[0];
  assign quad_s   = pin_s_q[1];
  assign late_s   = pin_s_q[2];
  assign bypass_s = ~pin_s_q[3];
  assign den_n_s  = pin_s_q[4];

  logic edge_any, edge_rise;
  assign edge_any  = data_s ^ data_prev_q;
  assign edge_rise = data_s & ~data_prev_q;

  // ****************************************
  // phase lock averaging window
  // ****************************************
  // a fixed window stands in for the rc filter; it needs only counters and a constant-scaled compare
  logic [10:0] win_q, trans_q, high_q;
  logic        phase_lock_q, win_end;
  assign win_end = (win_q == WIN_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_q   <= 11'h000;
      trans_q <= 11'h000;
      high_q  <= 11'h000;
    end else if (win_end) begin
      win_q   <= 11'h000;
      trans_q <= 11'h000;
      high_q  <= 11'h000;
    end else begin
      win_q <= win_q + 11'h001;
      if (edge_rise) begin
        trans_q <= trans_q + 11'h001;
        high_q  <= high_q + {10'h000, quad_s};
      end
    end
  end

  logic [17:0] high_scaled, trans_scaled;
  assign high_scaled  = 18'(high_q) * 18'(`SRXL_PL_THR_DEN);
  assign trans_scaled = 18'(trans_q) * 18'(`SRXL_PL_THR_NUM);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_lock_q     <= 1'b0;
      lock_filter_node <= 11'h000;
    end else if (win_end) begin
      phase_lock_q     <= (high_scaled > trans_scaled);
      lock_filter_node <= high_q;
    end
  end

  // ****************************************
  // integrator and acquisition sweep
  // ****************************************
  srxl_pkg::srxl_acq_t acq_q;
  logic [INTEG_W-1:0]  integ_q;
  logic                no_data_q, sweep_en_q, sat;
  logic [INTEG_W+1:0]  integ_sum;
  logic [1:0]          pd_step, sw_step;
  assign sat = (integ_q == '0) || (integ_q == INTEG_MAX);
  // with no transitions the integrator charges toward the top
  assign pd_step = !edge_any ? 2'b01 : (late_s ? 2'b01 : 2'b11);
  always_comb begin
    sw_step = 2'b00;
    if (sweep_en_q && acq_q == srxl_pkg::SRXL_ACQ_UP)
      sw_step = 2'b01;
    else if (sweep_en_q && acq_q == srxl_pkg::SRXL_ACQ_DOWN)
      sw_step = 2'b11;
  end
  assign integ_sum = {2'b00, integ_q} + {{INTEG_W{pd_step[1]}}, pd_step}
                   + {{INTEG_W{sw_step[1]}}, sw_step};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integ_q <= INTEG_MID;
    end else if (integ_sum[INTEG_W+1]) begin
      integ_q <= '0;
    end else if (integ_sum[INTEG_W]) begin
      integ_q <= INTEG_MAX;
    end else begin
      integ_q <= integ_sum[INTEG_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_q <= srxl_pkg::SRXL_ACQ_UP;
    end else begin
      case (acq_q)
        srxl_pkg::SRXL_ACQ_UP: begin
          if (phase_lock_q)
            acq_q <= srxl_pkg::SRXL_TRACK;
          else if (integ_q == INTEG_MAX)
            acq_q <= srxl_pkg::SRXL_ACQ_DOWN;
        end
        srxl_pkg::SRXL_ACQ_DOWN: begin
          if (phase_lock_q)
            acq_q <= srxl_pkg::SRXL_TRACK;
          else if (integ_q == '0)
            acq_q <= srxl_pkg::SRXL_ACQ_UP;
        end
        srxl_pkg::SRXL_TRACK: begin
          if (!phase_lock_q)
            acq_q <= srxl_pkg::SRXL_ACQ_UP;
        end
        default: acq_q <= srxl_pkg::SRXL_ACQ_UP;
      endcase
    end
  end

  // loop keeps running in bypass; lock never looks at bypass_s
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      no_data_q        <= 1'b1;
      lock             <= 1'b0;
      integrator_level <= INTEG_MID;
    end else begin
      no_data_q        <= sat;
      lock             <= phase_lock_q & ~no_data_q;
      integrator_level <= integ_q;
    end
  end

  // ****************************************
  // serial output path
  // ****************************************
  logic retime_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retime_q              <= 1'b0;
      retimed_serial_out    <= 1'b0;
      retimed_serial_out_oe <= 1'b0;
    end else begin
      retime_q <= data_s;
      if (bypass_s)
        retimed_serial_out <= data_s;
      else
        retimed_serial_out <= retime_q & lock;
      retimed_serial_out_oe <= ~den_n_s;
    end
  end

  // ****************************************
  // deserializer
  // ****************************************
  logic [4:0]  bit_cnt_q;
  logic [19:0] shreg_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_q <= 5'h00;
      shreg_q   <= 20'h0_0000;
      word_data <= 20'h0_0000;
      word_clk  <= 1'b0;
    end else begin
      // counter ignores lock so the word clock freewheels
      if (bit_cnt_q == 5'(`SRXL_WORD_BITS - 1))
        bit_cnt_q <= 5'h00;
      else
        bit_cnt_q <= bit_cnt_q + 5'h01;
      shreg_q <= {data_s, shreg_q[19:1]};
      if (bit_cnt_q == 5'(`SRXL_WORD_BITS - 1))
        word_data <= {data_s, shreg_q[19:1]};
      word_clk <= (bit_cnt_q < 5'(`SRXL_WORD_HALF));
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [2:0] int_stat_q, int_en_q, int_ev, int_clr;
  logic       lock_prev_q, nd_prev_q;
  assign int_ev = {no_data_q & ~nd_prev_q, lock_prev_q & ~lock,
                   lock & ~lock_prev_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_prev_q <= 1'b0;
      nd_prev_q   <= 1'b1;
      int_stat_q  <= 3'h0;
      irq         <= 1'b0;
    end else begin
      lock_prev_q <= lock;
      nd_prev_q   <= no_data_q;
      // set wins over a clear in the same cycle
      int_stat_q  <= (int_stat_q & ~int_clr) | int_ev;
      irq         <= |(int_stat_q & int_en_q);
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic       aw_have_q, w_have_q, do_wr;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign int_clr = (do_wr && aw_addr_q == `SRXL_OFS_INT_CLR && w_strb_q[0])
                 ? w_data_q[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= srxl_pkg::SRXL_RESP_OKAY;
      sweep_en_q   <= 1'(`SRXL_CTRL_RST);
      int_en_q     <= 3'h0;
    end else begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= srxl_pkg::SRXL_RESP_OKAY;
        case (aw_addr_q)
          `SRXL_OFS_CTRL: begin
            if (w_strb_q[0])
              sweep_en_q <= w_data_q[`SRXL_CTRL_SWEEP_EN];
          end
          `SRXL_OFS_INT_EN: begin
            if (w_strb_q[0])
              int_en_q <= w_data_q[2:0];
          end
          `SRXL_OFS_INT_CLR: begin
          end
          default: s_axi_bresp <= srxl_pkg::SRXL_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `SRXL_OFS_CTRL:     rd_word = {31'h0, sweep_en_q};
      `SRXL_OFS_STATUS:   rd_word = {26'h0, acq_q, bypass_s, no_data_q,
                                     phase_lock_q, lock};
      `SRXL_OFS_INT_STAT: rd_word = {29'h0, int_stat_q};
      `SRXL_OFS_INT_EN:   rd_word = {29'h0, int_en_q};
      `SRXL_OFS_INT_CLR:  rd_word = 32'h0000_0000;
      `SRXL_OFS_FILTER:   rd_word = {5'h00, trans_q, 5'h00, lock_filter_node};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= srxl_pkg::SRXL_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? srxl_pkg::SRXL_RESP_OKAY
                                : srxl_pkg::SRXL_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_lock_needs_both: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lock |-> ($past(phase_lock_q) && !$past(no_data_q)))
    else $error("lock high without phase lock and data");

  chk_sat_no_data: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (integ_q == INTEG_MAX || integ_q == '0) |=> no_data_q)
    else $error("saturation did not flag missing data");

  chk_sweep_stops: assert property (
    @(posedge aclk) disable iff (!aresetn)
    phase_lock_q |=> (acq_q == srxl_pkg::SRXL_TRACK))
    else $error("sweep still running under phase lock");

  chk_sweep_reverse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (acq_q == srxl_pkg::SRXL_ACQ_UP && integ_q == INTEG_MAX && !phase_lock_q)
    |=> (acq_q == srxl_pkg::SRXL_ACQ_DOWN))
    else $error("sweep did not reverse at top");

  chk_phase_thresh: assert property (
    @(posedge aclk) disable iff (!aresetn)
    win_end |=> (phase_lock_q ==
      ($past(high_q) * 100 > $past(trans_q) * 66)))
    else $error("phase lock disagrees with 0.66 threshold");

  chk_bypass_nomute: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bypass_s |=> (retimed_serial_out == $past(data_s)))
    else $error("bypass output not following input");

  chk_driver_enable: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 (retimed_serial_out_oe == !$past(den_n_s)))
    else $error("driver enable level not obeyed");

  chk_word_clk_rate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(word_clk) |-> ##20 $rose(word_clk))
    else $error("word clock not one twentieth of bit rate");

  chk_word_order: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_cnt_q == 5'd19) |=>
      (word_data[19] == $past(data_s) && word_data[0] == $past(data_s, 20)))
    else $error("word bit order wrong");

  cov_lock_rise: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(lock));
  cov_bypass_locked: cover property (@(posedge aclk) disable iff (!aresetn)
    bypass_s && lock);
  cov_sweep_flip: cover property (@(posedge aclk) disable iff (!aresetn)
    acq_q == srxl_pkg::SRXL_ACQ_UP ##1 acq_q == srxl_pkg::SRXL_ACQ_DOWN);
endmodule
`default_nettype wire

// file: dv/srxl_src.sv
`default_nettype none
// ****************************************
// serial source behind the cable equalizer
// ****************************************
module srxl_src (
  // clock and scenario control
  input  wire logic        aclk,
  input  wire logic [1:0]  mode,
  input  wire logic [19:0] pattern,
  input  wire logic [4:0]  level,
  // pins toward the receiver
  output var  logic        data,
  output var  logic        quad,
  output var  logic        late
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] pos_q;
  initial begin
    data  = 1'b0;
    quad  = 1'b0;
    late  = 1'b0;
    pos_q = 5'h00;
  end
  // mode 0 idle, 1 locked stream, 2 unlocked stream
  always @(posedge aclk) begin
    pos_q <= (pos_q == 5'd19) ? 5'd0 : pos_q + 5'd1;
    late  <= (level < 5'd16); // phase detector pulls toward mid
    if (mode == 2'd0) begin
      data <= 1'b0; // no carrier: no transitions at all
      quad <= ~quad;
    end else begin
      data <= pattern[pos_q];
      if (mode == 2'd1) begin
        quad <= 1'b1;
      end else if (!data && pattern[pos_q]) begin
        quad <= ~quad;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
`include "srxl_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
  // ****************************************
  // signals
  // ****************************************
  logic        aclk, aresetn, sdata, quad, late, byp_n, en_n;
  logic        rso, rso_oe, word_clk, lock, irq;
  logic [19:0] word_data, pat;
  logic [4:0]  integ;
  logic [10:0] filt;
  logic [1:0]  mode;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  hist;
  logic [31:0] d;
  logic [1:0]  r;
  int          failures, num_checks;
  // short window and narrow integrator keep the run brief
  srxl_top #(.INTEG_W(5), .LPF_CYC(40)) srxl_top_inst (
    .aclk(aclk), .aresetn(aresetn), .serial_data_in(sdata),
    .quad_clk_level(quad), .pd_late(late), .bypass_sel_n(byp_n),
    .serial_out_driver_enable_n(en_n), .retimed_serial_out(rso),
    .retimed_serial_out_oe(rso_oe), .word_data(word_data),
    .word_clk(word_clk), .lock(lock), .integrator_level(integ),
    .lock_filter_node(filt), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  srxl_src srxl_src_inst (.aclk(aclk), .mode(mode), .pattern(pat),
    .level(integ), .data(sdata), .quad(quad), .late(late));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) hist <= {hist[6:0], sdata};
  // ****************************************
  // bus and helper tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rsp);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rsp);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!(s_axi_rvalid && !s_axi_arvalid)) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock !== v && n < 3000) begin
      @(posedge aclk);
      n++;
    end
  endtask
  function automatic logic is_rot(input logic [19:0] w, input logic [19:0] p);
    logic [39:0] pp;
    pp = {p, p};
    is_rot = 1'b0;
    for (int k = 0; k < 20; k++) if (pp[k+:20] === w) is_rot = 1'b1;
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    axr(`SRXL_OFS_CTRL, d, r);
    `CHK(d, `SRXL_CTRL_RST)
    axw(`SRXL_OFS_CTRL, 32'h0000_0000, r);
    axr(`SRXL_OFS_CTRL, d, r);
    `CHK(d, 32'h0000_0000)
    axw(`SRXL_OFS_CTRL, `SRXL_CTRL_RST, r);
    axr(8'h20, d, r);
    `CHK(r, srxl_pkg::SRXL_RESP_SLVERR)
    axw(`SRXL_OFS_STATUS, 32'h0000_0001, r);
    `CHK(r, srxl_pkg::SRXL_RESP_SLVERR)
    axr(`SRXL_OFS_INT_CLR, d, r);
    `CHK(d, 32'h0000_0000)
    axw(`SRXL_OFS_INT_EN, 32'h0000_0001, r);
    axr(`SRXL_OFS_INT_EN, d, r);
    `CHK(d, 32'h0000_0001)
    $display("test regs done");
  endtask
  task automatic t_oe();
    en_n <= 1'b1;
    cyc(6);
    `CHK(rso_oe, 1'b0)
    en_n <= 1'b0;
    cyc(6);
    `CHK(rso_oe, 1'b1)
    $display("test driver enable done");
  endtask
  task automatic t_lock();
    int m;
    mode <= 2'd1;
    pat <= 20'hA_AAAA;
    wait_lock(1'b1);
    `CHK(lock, 1'b1)
    m = 0;
    repeat (20) begin @(posedge aclk); m += (rso !== hist[3]); end
    `CHK(m, 0)
    cyc(3);
    `CHK(irq, 1'b1)
    axr(`SRXL_OFS_INT_STAT, d, r);
    `CHK(d[0], 1'b1)
    axw(`SRXL_OFS_INT_EN, 32'h0000_0000, r);
    cyc(2);
    `CHK(irq, 1'b0)
    axw(`SRXL_OFS_INT_CLR, 32'h0000_0001, r);
    axr(`SRXL_OFS_INT_STAT, d, r);
    `CHK(d[0], 1'b0)
    cyc(40);
    `CHK(filt >= 11'd19 && filt <= 11'd20, 1'b1)
    $display("test lock done");
  endtask
  task automatic t_unlock();
    int hi, lo, ones, m2, m3;
    mode <= 2'd2;
    wait_lock(1'b0);
    `CHK(lock, 1'b0)
    hi = 0; lo = 0; ones = 0; m2 = 0; m3 = 0;
    while (word_clk !== 1'b0 && lo < 40) begin @(posedge aclk); lo++; end
    while (word_clk !== 1'b1 && lo < 80) begin @(posedge aclk); lo++; end
    lo = 0;
    while (word_clk === 1'b1 && hi < 40) begin @(posedge aclk); hi++; end
    while (word_clk === 1'b0 && lo < 40) begin @(posedge aclk); lo++; end
    `CHK(hi + lo, 20)
    `CHK(hi, 10)
    repeat (40) begin @(posedge aclk); ones += (rso !== 1'b0); end
    `CHK(ones, 0)
    `CHK(filt >= 11'd9 && filt <= 11'd10, 1'b1)
    byp_n <= 1'b0;
    cyc(6);
    repeat (40) begin
      @(posedge aclk);
      m2 += (rso !== hist[2]);
      m3 += (rso !== hist[3]);
    end
    `CHK((m2 == 0) || (m3 == 0), 1'b1)
    $display("test unlock and bypass done");
  endtask
  task automatic t_byp_lock();
    mode <= 2'd1;
    wait_lock(1'b1);
    `CHK(lock, 1'b1)
    byp_n <= 1'b1;
    $display("test bypass lock done");
  endtask
  task automatic t_words();
    logic [19:0] w0;
    pat <= 20'h0_0013;
    cyc(80);
    w0 = word_data;
    `CHK(is_rot(word_data, 20'h0_0013), 1'b1)
    repeat (2) begin
      cyc(20);
      `CHK(word_data, w0)
    end
    $display("test words done");
  endtask
  task automatic t_nodata();
    int n;
    n = 0;
    mode <= 2'd0;
    while (integ !== 5'd0 && integ !== 5'd31 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    `CHK(integ === 5'd0 || integ === 5'd31, 1'b1)
    cyc(4);
    `CHK(lock, 1'b0)
    axr(`SRXL_OFS_STATUS, d, r);
    `CHK(d[2], 1'b1)
    $display("test no data done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    close_out();
  end
  initial begin
    failures = 0; num_checks = 0; aresetn = 1'b0; byp_n = 1'b1;
    en_n = 1'b0; mode = 2'd0; pat = 20'h0_0000;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(4);
    t_regs();
    t_oe();
    t_lock();
    t_unlock();
    t_byp_lock();
    t_words();
    t_nodata();
    close_out();
  end
endmodule
`default_nettype wire
